// *** verilog/sram_core.sv ***
// pipelined burst synchronous sram, device side, with snooze and double-cycle deselect
//
// How it works
// - while snooze_request is high no synchronous input is acted on, well inside two cycles.
// - after snooze_request falls, two further edges are ignored before inputs are sampled again.
// - low_power rises at the first edge that sees snooze_request high.
// - low_power falls at the first edge that sees snooze_request low, independent of the wake wait.
// - burst beats follow xor order when burst_order_select is high, incrementing order when low.
// - after a deselect command the data outputs are off by the second edge.
// - reads never look at the per-lane write enables.
// - an access writes on all_bytes_write_n low or on byte_write_gate_n low with any lane low, except a processor-strobe start.
`timescale 1ns/1ps
`include "sram_params.svh"

module sram_core (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [`SRAM_ADDR_W-1:0] addr,
	input wire logic processor_address_strobe_n,
	input wire logic controller_address_strobe_n,
	input wire logic burst_step_n,
	input wire logic chip_select_low_a,
	input wire logic chip_select_high,
	input wire logic chip_select_low_b,
	input wire logic all_bytes_write_n,
	input wire logic byte_write_gate_n,
	input wire logic [`SRAM_LANES-1:0] byte_lane_write_enables_n,
	input wire logic output_enable_n,
	input wire logic snooze_request,
	input wire logic burst_order_select,
	input wire logic [`SRAM_DATA_W-1:0] dq_in,
	output logic [`SRAM_DATA_W-1:0] dq_out,
	output logic dq_oe,
	output logic low_power
);

	// ****************************************
	// state and storage
	// ****************************************
	sram_pkg::core_state_t st;
	sram_pkg::core_state_t next_st;
	sram_pkg::cmd_t cmd;
	logic [`SRAM_DATA_W-1:0] mem [0:(1<<`SRAM_ADDR_W)-1];
	logic [`SRAM_DATA_W-1:0] mem_q;
	logic [`SRAM_ADDR_W-1:0] addr_used;
	logic [`SRAM_LANES-1:0] mem_we;
	logic [`SRAM_LANES-1:0] lane_we;
	logic [`SRAM_BEAT_W-1:0] step_cnt;
	logic accept;
	logic enabled;
	logic start_p;
	logic start_c;
	logic write_req;
	logic is_write;
	logic access;

	function automatic logic [`SRAM_BEAT_W-1:0] beat(input logic [`SRAM_BEAT_W-1:0] b,
		input logic [`SRAM_BEAT_W-1:0] c, input logic il);
		// only the low bits move, so a burst wraps in its aligned group
		return il ? (b ^ c) : `SRAM_BEAT_W'(b + c);
	endfunction

	// ****************************************
	// decode and next state
	// ****************************************
	always_comb begin
		next_st = st;
		enabled = !chip_select_low_a && chip_select_high && !chip_select_low_b;
		// processor strobe is only honoured with the low-active select asserted
		start_p = !processor_address_strobe_n && !chip_select_low_a;
		start_c = !controller_address_strobe_n && !start_p;
		write_req = !all_bytes_write_n || (!byte_write_gate_n && byte_lane_write_enables_n != `SRAM_LANES_OFF);
		if (!all_bytes_write_n) begin
			lane_we = `SRAM_LANES_OFF;
		end else if (!byte_write_gate_n) begin
			lane_we = ~byte_lane_write_enables_n;
		end else begin
			lane_we = '0;
		end
		accept = !snooze_request && st.wake == '0;
		step_cnt = `SRAM_BEAT_W'(st.cnt + 1'b1);
		addr_used = {st.base[`SRAM_ADDR_W-1:`SRAM_BEAT_W], beat(st.base[`SRAM_BEAT_W-1:0], st.cnt, st.order)};
		is_write = 1'b0;
		if (!accept) begin
			cmd = sram_pkg::CMD_IDLE;
		end else if (start_p || start_c) begin
			cmd = enabled ? sram_pkg::CMD_START : sram_pkg::CMD_DESEL;
		end else if (st.burst_on && !burst_step_n) begin
			cmd = sram_pkg::CMD_STEP;
		end else if (st.burst_on) begin
			cmd = sram_pkg::CMD_HOLD;
		end else begin
			cmd = sram_pkg::CMD_IDLE;
		end
		case (cmd)
			sram_pkg::CMD_START: begin
				addr_used = addr;
				next_st.base = addr;
				next_st.cnt = '0;
				next_st.burst_on = 1'b1;
				// a processor-strobe start is always a read; writes follow on later beats
				is_write = start_c && write_req;
			end
			sram_pkg::CMD_STEP: begin
				next_st.cnt = step_cnt;
				addr_used = {st.base[`SRAM_ADDR_W-1:`SRAM_BEAT_W],
					beat(st.base[`SRAM_BEAT_W-1:0], step_cnt, st.order)};
				is_write = write_req;
			end
			sram_pkg::CMD_HOLD: begin
				is_write = write_req;
			end
			sram_pkg::CMD_DESEL: begin
				next_st.burst_on = 1'b0;
			end
			sram_pkg::CMD_IDLE: begin
				next_st.burst_on = st.burst_on;
			end
			default: begin
				next_st.burst_on = 1'b0;
			end
		endcase
		access = cmd == sram_pkg::CMD_START || cmd == sram_pkg::CMD_STEP || cmd == sram_pkg::CMD_HOLD;
		mem_we = (access && is_write) ? lane_we : '0;
		next_st.rd_v1 = access && !is_write;
		if (snooze_request) begin
			next_st.low_power = 1'b1;
			next_st.wake = `SRAM_WAKE_W'(`SRAM_SNOOZE_WAKE_CYC);
			next_st.burst_on = 1'b0;
			next_st.rd_v1 = 1'b0;
		end else begin
			next_st.low_power = 1'b0;
			if (st.wake != '0) begin
				next_st.wake = `SRAM_WAKE_W'(st.wake - 1'b1);
			end
		end
		// second pipeline stage: the output drivers follow the first stage, gated by output_enable_n and snooze_request
		next_st.dq_oe = st.rd_v1 && !output_enable_n && !snooze_request;
		next_st.dq_out = st.rd_v1 ? mem_q : st.dq_out;
		next_st.order_sync = {st.order_sync[1:0], burst_order_select};
		if (st.order_sync[1] == st.order_sync[2]) begin
			next_st.order = st.order_sync[2];
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '{low_power: 1'b0, wake: '0, burst_on: 1'b0, base: '0, cnt: '0, rd_v1: 1'b0, dq_oe: 1'b0,
				dq_out: '0, order_sync: {3{`SRAM_ORDER_RESET}}, order: `SRAM_ORDER_RESET};
		end else begin
			st <= next_st;
		end
	end

	// array has no reset; contents are undefined until written
	always_ff @(posedge mclk) begin
		for (int i = 0; i < `SRAM_LANES; i++) begin
			if (mem_we[i]) begin
				mem[addr_used][i*`SRAM_LANE_W +: `SRAM_LANE_W] <= dq_in[i*`SRAM_LANE_W +: `SRAM_LANE_W];
			end
		end
		mem_q <= mem[addr_used];
	end

	assign dq_out = st.dq_out;
	assign dq_oe = st.dq_oe;
	assign low_power = st.low_power;

	// ****************************************
	// checks
	// ****************************************
	a_snooze_ignores: assert property (@(posedge mclk) disable iff (!rst_b)
		snooze_request |-> !accept ##1 (!st.rd_v1 && !st.burst_on))
		else $error("input acted on during snooze");

	a_wake_gap: assert property (@(posedge mclk) disable iff (!rst_b)
		$fell(snooze_request) |-> !accept ##1 !accept)
		else $error("input sampled inside wake gap");

	a_snooze_entry: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(snooze_request) |=> low_power)
		else $error("low power not reached in time");

	a_snooze_exit: assert property (@(posedge mclk) disable iff (!rst_b)
		(st.low_power && !snooze_request) |=> !low_power && (st.wake == `SRAM_WAKE_W'(1)))
		else $error("low power not left at once");

	a_burst_xor: assert property (@(posedge mclk) disable iff (!rst_b)
		(cmd == sram_pkg::CMD_START && st.order) ##1 (cmd == sram_pkg::CMD_STEP)
		|-> addr_used == {$past(addr[`SRAM_ADDR_W-1:`SRAM_BEAT_W]), $past(addr[1:0]) ^ 2'h1})
		else $error("interleaved beat wrong");

	a_burst_wrap: assert property (@(posedge mclk) disable iff (!rst_b)
		(cmd == sram_pkg::CMD_START && !st.order && addr[1:0] == 2'h3) ##1 (cmd == sram_pkg::CMD_STEP)
		|-> addr_used == {$past(addr[`SRAM_ADDR_W-1:`SRAM_BEAT_W]), 2'h0})
		else $error("linear beat did not wrap");

	a_deselect_off: assert property (@(posedge mclk) disable iff (!rst_b)
		(cmd == sram_pkg::CMD_DESEL) |-> ##2 !dq_oe)
		else $error("outputs on after deselect");

	// a processor-strobe start reads whatever the lane enables say
	a_read_no_lanes: assert property (@(posedge mclk) disable iff (!rst_b)
		(access && ((cmd == sram_pkg::CMD_START && !processor_address_strobe_n && !chip_select_low_a)
		|| (all_bytes_write_n && byte_write_gate_n))) |-> mem_we == '0 ##1 st.rd_v1)
		else $error("read disturbed by lane enables");

	a_write_decode: assert property (@(posedge mclk) disable iff (!rst_b)
		(access && processor_address_strobe_n && !all_bytes_write_n) |-> mem_we == `SRAM_LANES_OFF ##1 !st.rd_v1)
		else $error("global write not decoded");

	a_power_follows: assert property (@(posedge mclk) disable iff (!rst_b)
		!snooze_request |=> !low_power)
		else $error("low power held without request");

	a_wake_first: assert property (@(posedge mclk) disable iff (!rst_b)
		$fell(snooze_request) ##1 !snooze_request ##1 !snooze_request |-> accept)
		else $error("input not sampled after wake gap");

endmodule

// *** include/sram_params.svh ***
// constants for the burst sram device core
`ifndef SRAM_PARAMS_SVH
`define SRAM_PARAMS_SVH

`define SRAM_ADDR_W 20
`define SRAM_DATA_W 32
`define SRAM_LANES 4
`define SRAM_LANE_W 8
`define SRAM_BEAT_W 2
// snooze latencies, in clock cycles
`define SRAM_SNOOZE_ENTRY_CYC 2
`define SRAM_SNOOZE_WAKE_CYC 2
`define SRAM_WAKE_W 2
// unconnected order pin reads high: interleaved
`define SRAM_ORDER_RESET 1'b1
`define SRAM_LANES_OFF 4'hf

`endif

// *** include/sram_pkg.sv ***
// types shared by the burst sram device core
`include "sram_params.svh"

package sram_pkg;

	typedef enum logic [2:0] {
		CMD_IDLE = 3'b000,
		CMD_DESEL = 3'b001,
		CMD_START = 3'b010,
		CMD_STEP = 3'b011,
		CMD_HOLD = 3'b100
	} cmd_t;

	typedef struct packed {
		logic low_power;
		logic [`SRAM_WAKE_W-1:0] wake;
		logic burst_on;
		logic [`SRAM_ADDR_W-1:0] base;
		logic [`SRAM_BEAT_W-1:0] cnt;
		logic rd_v1;
		logic dq_oe;
		logic [`SRAM_DATA_W-1:0] dq_out;
		logic [2:0] order_sync;
		logic order;
	} core_state_t;

endpackage

// *** bench/sram_ctrl_model.sv ***
// controller-side model that drives the sram core pins
`timescale 1ns/1ps
`include "sram_params.svh"
module sram_ctrl_model (
	input wire logic mclk,
	output logic [`SRAM_ADDR_W-1:0] addr,
	output logic processor_address_strobe_n,
	output logic controller_address_strobe_n,
	output logic burst_step_n,
	output logic chip_select_low_a,
	output logic chip_select_high,
	output logic chip_select_low_b,
	output logic all_bytes_write_n,
	output logic byte_write_gate_n,
	output logic [`SRAM_LANES-1:0] byte_lane_write_enables_n,
	output logic output_enable_n,
	output logic snooze_request,
	output logic burst_order_select,
	output logic [`SRAM_DATA_W-1:0] dq_in
);
	logic w;
	initial begin
		{addr, dq_in} = '0;
		{processor_address_strobe_n, controller_address_strobe_n, burst_step_n, all_bytes_write_n} = 4'hf;
		{byte_write_gate_n, chip_select_low_a, chip_select_low_b, output_enable_n} = 4'hf;
		{chip_select_high, byte_lane_write_enables_n} = 5'h0f;
		{snooze_request, burst_order_select} = 2'h1;
	end
	// one edge per call; all pins held until the next call
	task automatic cyc(input logic sel, ps, cs, st, gw, bg, input logic [`SRAM_LANES-1:0] ln,
		input logic [`SRAM_ADDR_W-1:0] a, input logic [`SRAM_DATA_W-1:0] d);
		@(posedge mclk);
		#1;
		w = ps && (!gw || (!bg && ln != 4'hf));
		{chip_select_low_a, chip_select_high, chip_select_low_b} = {!sel, sel, !sel};
		{processor_address_strobe_n, controller_address_strobe_n, burst_step_n} = {ps, cs, st};
		{all_bytes_write_n, byte_write_gate_n, byte_lane_write_enables_n} = {gw, bg, ln};
		addr = a;
		output_enable_n = w;
		// a released data bus must not look like the last word
		dq_in = w ? d : ~dq_in;
	endtask
	task automatic pins(input logic zz, ord);
		@(posedge mclk);
		#1;
		{snooze_request, burst_order_select} = {zz, ord};
	endtask
endmodule

// *** bench/tb.sv ***
// self-checking bench for the burst sram core
`timescale 1ns/1ps
`include "sram_params.svh"
module tb;
	logic mclk, rst_b, processor_address_strobe_n, controller_address_strobe_n, burst_step_n, chip_select_low_a;
	logic chip_select_high, chip_select_low_b, all_bytes_write_n, byte_write_gate_n, output_enable_n;
	logic snooze_request, burst_order_select, dq_oe, low_power;
	logic [`SRAM_ADDR_W-1:0] addr, base;
	logic [`SRAM_LANES-1:0] byte_lane_write_enables_n;
	logic [`SRAM_DATA_W-1:0] dq_in, dq_out, seed, e, mem [0:3];
	logic [`SRAM_DATA_W-1:0] q [$];
	int n_fail, comparisons, i, k, o;
	sram_ctrl_model ctl (.mclk, .addr, .processor_address_strobe_n, .controller_address_strobe_n, .burst_step_n,
		.chip_select_low_a, .chip_select_high, .chip_select_low_b, .all_bytes_write_n, .byte_write_gate_n,
		.byte_lane_write_enables_n, .output_enable_n, .snooze_request, .burst_order_select, .dq_in);
	sram_core DUT (.mclk, .rst_b, .addr, .processor_address_strobe_n, .controller_address_strobe_n, .burst_step_n,
		.chip_select_low_a, .chip_select_high, .chip_select_low_b, .all_bytes_write_n, .byte_write_gate_n,
		.byte_lane_write_enables_n, .output_enable_n, .snooze_request, .burst_order_select, .dq_in,
		.dq_out, .dq_oe, .low_power);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] x, g);
		comparisons++;
		if (x !== g) begin
			n_fail++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, x, g);
		end
	endtask
	task automatic end_of_test;
		$display("fails=%0d comparisons=%0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		#20000;
		n_fail++;
		end_of_test;
	end
	// every driven cycle is one read result, oldest note first
	always @(negedge mclk) begin
		if (rst_b === 1'b1 && dq_oe === 1'b1) begin
			if (q.size() == 0) chk(32'h0, {31'h0, dq_oe});
			else chk(q.pop_front(), dq_out);
		end
	end
	initial begin
		rst_b = 1'b0;
		seed = 32'h0b55;
		base = 20'h00a5c;
		repeat (4) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			mem[i] = seed;
			// first word opens a burst, the others are continued writes on its beats
			if (i[0]) ctl.cyc(1'b1, 1'b1, i != 0, i == 0, 1'b1, 1'b0, 4'h0, base + 20'(i), seed);
			else ctl.cyc(1'b1, 1'b1, i != 0, i == 0, 1'b0, 1'b1, 4'hf, base + 20'(i), seed);
		end
		seed = lfsr(seed);
		mem[3][23:16] = seed[23:16];
		ctl.cyc(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'hb, base + 20'h3, seed);
		ctl.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, base, seed);
		$display("test writes done");
		for (o = 1; o >= 0; o--) begin
			// order strap passes a three-flop synchroniser
			ctl.pins(1'b0, o[0]);
			repeat (4) @(posedge mclk);
			// starting on the last word of the group makes the linear burst wrap
			for (k = 0; k < 4; k++) begin
				e = mem[o[0] ? (2'd3 ^ k[1:0]) : (2'd3 + k[1:0])];
				q.push_back(e);
				seed = lfsr(seed);
				if (k == 0) ctl.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, seed[3:0], base + 20'h3, seed);
				else ctl.cyc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, seed[3:0], base + 20'h3, seed);
				if (k == 2) q.push_back(e);
				if (k == 2) ctl.cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, seed[3:0], base + 20'h3, seed);
			end
			ctl.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, base, seed);
			repeat (2) @(posedge mclk);
			#2;
			chk(32'h0, {31'h0, dq_oe});
			$display("test burst order %0d done", o);
		end
		ctl.pins(1'b1, 1'b0);
		ctl.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, base + 20'h1, seed);
		ctl.cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, base, seed);
		@(posedge mclk);
		#2;
		chk(32'h1, {31'h0, low_power});
		chk(32'h0, {31'h0, dq_oe});
		ctl.pins(1'b0, 1'b0);
		@(posedge mclk);
		#2;
		chk(32'h0, {31'h0, low_power});
		q.push_back(mem[1]);
		ctl.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, base + 20'h1, seed);
		ctl.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, base, seed);
		repeat (3) @(posedge mclk);
		$display("test snooze done");
		chk(32'h0, 32'(q.size()));
		end_of_test;
	end
endmodule
